// >>> rtl/srt_sync_edge.sv
// Two-flop synchroniser with a rising edge detector behind it.
`timescale 1ns/100ps
`default_nettype none
module srt_sync_edge (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic async_i,
  output logic rise_o
);
  import srt_pkg::*;
  srt_sync_t st_ff;
  srt_sync_t nxt_st;
  // ==========================================================
  // Shift chain; the edge detector looks only past the second flop.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = async_i;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
  end
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  // Rising edge of the synchronised level.
  assign rise_o = st_ff.s2 & ~st_ff.s3;
endmodule // srt_sync_edge
`default_nettype wire

// >>> rtl/srt_timer_ctrl.sv
// Split reload timer with control register, capture mode and interrupt request.
`timescale 1ns/100ps
`default_nettype none
module srt_timer_ctrl (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic [srt_pkg::SRT_AW-1:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [srt_pkg::SRT_DW-1:0] sfr_wdata_i,
  input wire logic timer_irq_enable_i,
  input wire logic high_byte_clock_select_i,
  input wire logic low_byte_clock_select_i,
  input wire logic comparator_i,
  input wire logic ext_osc_i,
  output logic [srt_pkg::SRT_DW-1:0] sfr_rdata_o,
  output logic irq_o
);
  import srt_pkg::*;
  logic rst_meta_ff;
  logic rst_n_ff;
  srt_state_t st_ff;
  srt_state_t nxt_st;
  logic cmp_edge;
  logic osc_edge;
  logic sys12_tick;
  logic ext8_tick;
  logic ext_tick;
  logic trig;
  logic lo_tick;
  logic hi_tick;
  logic hset;
  logic lset;
  logic [1:0] xsel;
  logic wr_ctrl;
  // ==========================================================
  // Reset release through two flops.
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end
  // ==========================================================
  // Pin inputs are synchronised before any counting logic sees them.
  srt_sync_edge u_cmp_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_ff),
    .async_i(comparator_i),
    .rise_o(cmp_edge)
  );
  srt_sync_edge u_osc_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_ff),
    .async_i(ext_osc_i),
    .rise_o(osc_edge)
  );
  // ==========================================================
  // Next state: prescalers, counting, capture, software access.
  always_comb begin
    nxt_st = st_ff;
    hset = 1'b0;
    lset = 1'b0;
    wr_ctrl = sfr_wr_i && (sfr_addr_i == SRT_ADDR_CTRL);
    sys12_tick = (st_ff.div12 == SRT_SYS_LAST);
    nxt_st.div12 = sys12_tick ? 4'h0 : st_ff.div12 + 4'h1;
    ext8_tick = osc_edge && (st_ff.ext8 == SRT_EXT_LAST);
    if (osc_edge) begin
      nxt_st.ext8 = ext8_tick ? 3'h0 : st_ff.ext8 + 3'h1;
    end
    xsel = st_ff.ctrl[SRT_XCLK_MSB:SRT_XCLK_LSB];
    ext_tick = 1'b0;
    trig = 1'b0;
    // Code 10 falls back to the divided system clock and the comparator.
    unique case (xsel)
      SRT_XCLK_SYS12: begin
        ext_tick = sys12_tick;
        trig = cmp_edge;
      end
      SRT_XCLK_EXT8: begin
        ext_tick = ext8_tick;
        trig = ext8_tick;
      end
      SRT_XCLK_ALT12: begin
        ext_tick = sys12_tick;
        trig = cmp_edge;
      end
      SRT_XCLK_CMP: begin
        ext_tick = cmp_edge;
        trig = ext8_tick;
      end
    endcase
    // Each byte picks the system clock or the shared external clock.
    lo_tick = low_byte_clock_select_i ? 1'b1 : ext_tick;
    hi_tick = high_byte_clock_select_i ? 1'b1 : ext_tick;
    if (st_ff.ctrl[SRT_BIT_SPLIT]) begin
      // Low byte always runs in split mode.
      if (lo_tick) begin
        if (st_ff.count[7:0] == SRT_MAX8) begin
          nxt_st.count[7:0] = st_ff.reload[7:0];
          lset = 1'b1;
        end else begin
          nxt_st.count[7:0] = st_ff.count[7:0] + 8'h01;
        end
      end
      if (st_ff.ctrl[SRT_BIT_RUN] && hi_tick) begin
        if (st_ff.count[15:8] == SRT_MAX8) begin
          nxt_st.count[15:8] = st_ff.reload[15:8];
          hset = 1'b1;
        end else begin
          nxt_st.count[15:8] = st_ff.count[15:8] + 8'h01;
        end
      end
    end else if (st_ff.ctrl[SRT_BIT_RUN] && lo_tick) begin
      if (st_ff.count == SRT_MAX16) begin
        // In capture mode the reload pair holds captures, so wrap to zero.
        nxt_st.count = st_ff.ctrl[SRT_BIT_CAP] ? SRT_COUNT_RESET : st_ff.reload;
        hset = 1'b1;
        lset = 1'b1;
      end else begin
        nxt_st.count = st_ff.count + 16'h0001;
        lset = (st_ff.count[7:0] == SRT_MAX8);
      end
    end
    // Software writes to data registers win over counting.
    if (sfr_wr_i) begin
      unique case (sfr_addr_i)
        SRT_ADDR_CTRL: nxt_st.ctrl[SRT_BIT_LIRQ:0] = sfr_wdata_i[SRT_BIT_LIRQ:0];
        SRT_ADDR_RELOAD_LO: nxt_st.reload[7:0] = sfr_wdata_i;
        SRT_ADDR_RELOAD_HI: nxt_st.reload[15:8] = sfr_wdata_i;
        SRT_ADDR_COUNT_LO: nxt_st.count[7:0] = sfr_wdata_i;
        SRT_ADDR_COUNT_HI: nxt_st.count[15:8] = sfr_wdata_i;
        default: ;
      endcase
    end
    // Capture event wins over a reload write in the same cycle.
    if (st_ff.ctrl[SRT_BIT_CAP] && trig) begin
      nxt_st.reload = st_ff.count;
      hset = 1'b1;
    end
    // Flags: only a software write of zero clears; a hardware set wins.
    nxt_st.ctrl[SRT_BIT_HFLAG] = (wr_ctrl ? sfr_wdata_i[SRT_BIT_HFLAG]
      : st_ff.ctrl[SRT_BIT_HFLAG]) | hset;
    nxt_st.ctrl[SRT_BIT_LFLAG] = (wr_ctrl ? sfr_wdata_i[SRT_BIT_LFLAG]
      : st_ff.ctrl[SRT_BIT_LFLAG]) | lset;
    // Interrupt request is a level that follows the flags.
    nxt_st.irq = timer_irq_enable_i && (nxt_st.ctrl[SRT_BIT_HFLAG]
      || (nxt_st.ctrl[SRT_BIT_LFLAG] && nxt_st.ctrl[SRT_BIT_LIRQ]));
    // Registered read data, unmapped addresses read zero.
    unique case (sfr_addr_i)
      SRT_ADDR_CTRL: nxt_st.rdata = st_ff.ctrl;
      SRT_ADDR_RELOAD_LO: nxt_st.rdata = st_ff.reload[7:0];
      SRT_ADDR_RELOAD_HI: nxt_st.rdata = st_ff.reload[15:8];
      SRT_ADDR_COUNT_LO: nxt_st.rdata = st_ff.count[7:0];
      SRT_ADDR_COUNT_HI: nxt_st.rdata = st_ff.count[15:8];
      default: nxt_st.rdata = 8'h00;
    endcase
  end
  // State register.
  always_ff @(posedge mclk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      st_ff <= SRT_STATE_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign sfr_rdata_o = st_ff.rdata;
  assign irq_o = st_ff.irq;
  // ==========================================================
  // Checks on the timer behaviour.
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_ff);
  logic quiet;
  assign quiet = !sfr_wr_i;
  chk_hflag_sticky: assert property (
    st_ff.ctrl[SRT_BIT_HFLAG] && !(wr_ctrl && !sfr_wdata_i[SRT_BIT_HFLAG])
    |=> st_ff.ctrl[SRT_BIT_HFLAG]) else $error("High flag cleared without software.");
  chk_lflag_sticky: assert property (
    st_ff.ctrl[SRT_BIT_LFLAG] && !(wr_ctrl && !sfr_wdata_i[SRT_BIT_LFLAG])
    |=> st_ff.ctrl[SRT_BIT_LFLAG]) else $error("Low flag cleared without software.");
  chk_wrap16_reload: assert property (
    quiet && !st_ff.ctrl[SRT_BIT_SPLIT] && st_ff.ctrl[SRT_BIT_RUN] && !st_ff.ctrl[SRT_BIT_CAP]
    && low_byte_clock_select_i && st_ff.count == SRT_MAX16
    |=> st_ff.count == $past(st_ff.reload) && st_ff.ctrl[SRT_BIT_HFLAG])
    else $error("16-bit wrap did not reload and flag.");
  chk_split_high_wrap: assert property (
    quiet && st_ff.ctrl[SRT_BIT_SPLIT] && st_ff.ctrl[SRT_BIT_RUN] && high_byte_clock_select_i
    && st_ff.count[15:8] == SRT_MAX8 && !st_ff.ctrl[SRT_BIT_CAP]
    |=> st_ff.count[15:8] == $past(st_ff.reload[15:8]) && st_ff.ctrl[SRT_BIT_HFLAG])
    else $error("Split high byte wrap wrong.");
  chk_split_low_wrap: assert property (
    quiet && st_ff.ctrl[SRT_BIT_SPLIT] && low_byte_clock_select_i
    && st_ff.count[7:0] == SRT_MAX8
    |=> st_ff.count[7:0] == $past(st_ff.reload[7:0]) && st_ff.ctrl[SRT_BIT_LFLAG])
    else $error("Split low byte wrap wrong.");
  chk_low_free_run: assert property (
    quiet && st_ff.ctrl[SRT_BIT_SPLIT] && !st_ff.ctrl[SRT_BIT_RUN]
    && high_byte_clock_select_i && low_byte_clock_select_i
    |=> $stable(st_ff.count[15:8])
    && st_ff.count[7:0] == (($past(st_ff.count[7:0]) == SRT_MAX8)
    ? $past(st_ff.reload[7:0]) : $past(st_ff.count[7:0]) + 8'h01))
    else $error("Split run gating wrong.");
  chk_stopped_hold: assert property (
    quiet && !st_ff.ctrl[SRT_BIT_SPLIT] && !st_ff.ctrl[SRT_BIT_RUN] && !st_ff.ctrl[SRT_BIT_CAP]
    |=> $stable(st_ff.count)) else $error("Stopped timer moved.");
  chk_sys12_pace: assert property (
    quiet && !st_ff.ctrl[SRT_BIT_SPLIT] && st_ff.ctrl[SRT_BIT_RUN] && !st_ff.ctrl[SRT_BIT_CAP]
    && !low_byte_clock_select_i && !st_ff.ctrl[SRT_XCLK_LSB] && st_ff.div12 != SRT_SYS_LAST
    |=> $stable(st_ff.count)) else $error("Divided clock ticked early.");
  chk_capture_copy: assert property (
    quiet && st_ff.ctrl[SRT_BIT_CAP] && !st_ff.ctrl[SRT_XCLK_LSB] && cmp_edge
    |=> st_ff.reload == $past(st_ff.count) && st_ff.ctrl[SRT_BIT_HFLAG])
    else $error("Capture did not copy count.");
  chk_irq_high: assert property (
    $past(timer_irq_enable_i) && st_ff.ctrl[SRT_BIT_HFLAG] |-> irq_o)
    else $error("High flag raised no interrupt.");
  chk_irq_low: assert property (
    $past(timer_irq_enable_i) && st_ff.ctrl[SRT_BIT_LFLAG] && st_ff.ctrl[SRT_BIT_LIRQ]
    |-> irq_o) else $error("Low flag raised no interrupt.");
  chk_sync_delay: assert property (
    cmp_edge |-> $past(comparator_i, 2) && !$past(comparator_i, 3))
    else $error("Comparator edge not synchronised.");
  cov_wrap16: cover property (!st_ff.ctrl[SRT_BIT_SPLIT] && st_ff.count == SRT_MAX16
    ##1 st_ff.ctrl[SRT_BIT_HFLAG]);
  cov_split_low: cover property (st_ff.ctrl[SRT_BIT_SPLIT] && st_ff.ctrl[SRT_BIT_LFLAG]);
  cov_capture: cover property (st_ff.ctrl[SRT_BIT_CAP] && trig);
  cov_irq: cover property (irq_o);
endmodule // srt_timer_ctrl
`default_nettype wire

// >>> shared/srt_pkg.sv
// Constants and state types for the split reload timer control block.
package srt_pkg;
  // ==========================================================
  // Register addresses on the special function register port.
  localparam int SRT_AW = 8;
  localparam int SRT_DW = 8;
  localparam logic [7:0] SRT_ADDR_CTRL = 8'h91;
  localparam logic [7:0] SRT_ADDR_RELOAD_LO = 8'h92;
  localparam logic [7:0] SRT_ADDR_RELOAD_HI = 8'h93;
  localparam logic [7:0] SRT_ADDR_COUNT_LO = 8'h94;
  localparam logic [7:0] SRT_ADDR_COUNT_HI = 8'h95;
  // ==========================================================
  // Field positions of the timer control register.
  localparam int SRT_BIT_HFLAG = 7;
  localparam int SRT_BIT_LFLAG = 6;
  localparam int SRT_BIT_LIRQ = 5;
  localparam int SRT_BIT_CAP = 4;
  localparam int SRT_BIT_SPLIT = 3;
  localparam int SRT_BIT_RUN = 2;
  localparam int SRT_XCLK_MSB = 1;
  localparam int SRT_XCLK_LSB = 0;
  // ==========================================================
  // External clock select codes.
  localparam logic [1:0] SRT_XCLK_SYS12 = 2'h0;
  localparam logic [1:0] SRT_XCLK_EXT8 = 2'h1;
  localparam logic [1:0] SRT_XCLK_ALT12 = 2'h2;
  localparam logic [1:0] SRT_XCLK_CMP = 2'h3;
  // ==========================================================
  // Reset values and counting limits.
  localparam logic [7:0] SRT_CTRL_RESET = 8'h00;
  localparam logic [15:0] SRT_RELOAD_RESET = 16'h0000;
  localparam logic [15:0] SRT_COUNT_RESET = 16'h0000;
  localparam logic [15:0] SRT_MAX16 = 16'hffff;
  localparam logic [7:0] SRT_MAX8 = 8'hff;
  localparam int SRT_SYS_DIV = 12;
  localparam int SRT_EXT_DIV = 8;
  localparam logic [3:0] SRT_SYS_LAST = 4'(SRT_SYS_DIV - 1);
  localparam logic [2:0] SRT_EXT_LAST = 3'(SRT_EXT_DIV - 1);
  // ==========================================================
  // State of the timer control block.
  typedef struct packed {
    logic [7:0] ctrl;
    logic [15:0] reload;
    logic [15:0] count;
    logic [3:0] div12;
    logic [2:0] ext8;
    logic [7:0] rdata;
    logic irq;
  } srt_state_t;
  localparam srt_state_t SRT_STATE_RESET = '{ctrl: SRT_CTRL_RESET, reload: SRT_RELOAD_RESET,
    count: SRT_COUNT_RESET, div12: 4'h0, ext8: 3'h0, rdata: 8'h00, irq: 1'b0};
  // State of one input synchroniser with edge detector.
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } srt_sync_t;
endpackage

// >>> verification/srt_tb.sv
// Self-checking testbench for the split reload timer control block.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import srt_pkg::*;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic irq_en = 1'b0;
  logic hsel = 1'b1;
  logic lsel = 1'b1;
  logic gen_on = 1'b0;
  logic [3:0] gcnt = 4'h0;
  logic [7:0] rdata;
  logic irq;
  logic [7:0] d;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  // ==========================================
  // Clock and source generator that counts only while gen_on is set.
  initial begin
    forever #12.5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    gcnt <= gen_on ? gcnt + 4'h1 : 4'h0;
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fails = fails + 1;
      give_verdict();
    end
  end
  srt_timer_ctrl dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .sfr_addr_i(addr), .sfr_wr_i(wr),
    .sfr_wdata_i(wdata), .timer_irq_enable_i(irq_en), .high_byte_clock_select_i(hsel),
    .low_byte_clock_select_i(lsel), .comparator_i(gcnt[2]), .ext_osc_i(gcnt[1]),
    .sfr_rdata_o(rdata), .irq_o(irq));
  // ==========================================
  // Bus and compare tasks.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk_i);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk_i);
    addr <= a;
    @(posedge mclk_i);
    @(posedge mclk_i);
    #1 v = rdata;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks = n_checks + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_near(input string nm, input int e, input logic [7:0] g);
    n_checks = n_checks + 1;
    if ($isunknown(g) || (int'(g) > e + 1) || (int'(g) < e - 1)) begin
      fails = fails + 1;
      $display("[ERR] %s expected %0d seen %h", nm, e, g);
    end
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    rd(a, d);
    chk(nm, e, d);
  endtask
  // ==========================================
  // Scenarios.
  task automatic t_reset();
    rdchk("ctrl", SRT_ADDR_CTRL, SRT_CTRL_RESET);
    rdchk("reload_hi", SRT_ADDR_RELOAD_HI, 8'h00);
    rdchk("count_lo", SRT_ADDR_COUNT_LO, 8'h00);
    rdchk("unmapped", 8'h90, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_wrap16();
    @(posedge mclk_i);
    irq_en <= 1'b1;
    wr_reg(SRT_ADDR_RELOAD_LO, 8'h34);
    wr_reg(SRT_ADDR_RELOAD_HI, 8'h12);
    wr_reg(SRT_ADDR_COUNT_LO, 8'hfe);
    wr_reg(SRT_ADDR_COUNT_HI, 8'hff);
    wr_reg(SRT_ADDR_CTRL, 8'h04);
    repeat (8) @(posedge mclk_i);
    rdchk("ctrl_flags", SRT_ADDR_CTRL, 8'hc4);
    chk("irq_high", 8'h01, {7'h0, irq});
    repeat (50) @(posedge mclk_i);
    rdchk("ctrl_hold", SRT_ADDR_CTRL, 8'hc4);
    rdchk("count_hi_reload", SRT_ADDR_COUNT_HI, 8'h12);
    wr_reg(SRT_ADDR_CTRL, 8'h04);
    rdchk("ctrl_clear", SRT_ADDR_CTRL, 8'h04);
    chk("irq_clear", 8'h00, {7'h0, irq});
    $display("test wrap16 done");
  endtask
  task automatic t_split();
    wr_reg(SRT_ADDR_RELOAD_LO, 8'hf0);
    wr_reg(SRT_ADDR_CTRL, 8'h08);
    wr_reg(SRT_ADDR_COUNT_HI, 8'hff);
    wr_reg(SRT_ADDR_COUNT_LO, 8'hfe);
    repeat (6) @(posedge mclk_i);
    rdchk("split_ctrl", SRT_ADDR_CTRL, 8'h48);
    rdchk("split_hi_stopped", SRT_ADDR_COUNT_HI, 8'hff);
    rd(SRT_ADDR_COUNT_LO, d);
    chk("split_lo_reload", 8'hfc, d);
    chk("irq_low_masked", 8'h00, {7'h0, irq});
    wr_reg(SRT_ADDR_CTRL, 8'h68);
    @(posedge mclk_i);
    #1 chk("irq_low", 8'h01, {7'h0, irq});
    wr_reg(SRT_ADDR_CTRL, 8'h0c);
    repeat (4) @(posedge mclk_i);
    rd(SRT_ADDR_CTRL, d);
    chk("split_high_flag", 8'h80, d & 8'h80);
    $display("test split done");
  endtask
  task automatic t_clocks();
    logic [7:0] exp_tab [4];
    exp_tab = '{8'd16, 8'd6, 8'd16, 8'd24};
    @(posedge mclk_i);
    lsel <= 1'b0;
    gen_on <= 1'b1;
    wr_reg(SRT_ADDR_CTRL, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr_reg(SRT_ADDR_COUNT_LO, 8'h00);
      wr_reg(SRT_ADDR_COUNT_HI, 8'h00);
      wr_reg(SRT_ADDR_CTRL, 8'h04 | 8'(c));
      repeat (192) @(posedge mclk_i);
      wr_reg(SRT_ADDR_CTRL, 8'h00);
      rd(SRT_ADDR_COUNT_LO, d);
      chk_near("ext_clock_ticks", int'(exp_tab[c]), d);
    end
    $display("test clocks done");
  endtask
  task automatic t_capture();
    @(posedge mclk_i);
    lsel <= 1'b1;
    wr_reg(SRT_ADDR_RELOAD_HI, 8'haa);
    wr_reg(SRT_ADDR_COUNT_LO, 8'h00);
    wr_reg(SRT_ADDR_COUNT_HI, 8'h00);
    wr_reg(SRT_ADDR_CTRL, 8'h14);
    repeat (40) @(posedge mclk_i);
    rdchk("cap_ctrl", SRT_ADDR_CTRL, 8'h94);
    rdchk("cap_reload_hi", SRT_ADDR_RELOAD_HI, 8'h00);
    chk("cap_irq", 8'h01, {7'h0, irq});
    $display("test capture done");
  endtask
  // Split high byte on the comparator clock, then capture on the oscillator.
  task automatic t_ext_mix();
    @(posedge mclk_i);
    hsel <= 1'b0;
    wr_reg(SRT_ADDR_CTRL, 8'h08);
    wr_reg(SRT_ADDR_COUNT_HI, 8'h00);
    wr_reg(SRT_ADDR_CTRL, 8'h0f);
    repeat (158) @(posedge mclk_i);
    wr_reg(SRT_ADDR_CTRL, 8'h08);
    rdchk("split_hi_ext_clock", SRT_ADDR_COUNT_HI, 8'h14);
    wr_reg(SRT_ADDR_RELOAD_HI, 8'h55);
    wr_reg(SRT_ADDR_COUNT_LO, 8'h00);
    wr_reg(SRT_ADDR_COUNT_HI, 8'h00);
    wr_reg(SRT_ADDR_CTRL, 8'h15);
    repeat (40) @(posedge mclk_i);
    rdchk("cap_osc_ctrl", SRT_ADDR_CTRL, 8'h95);
    rdchk("cap_osc_reload_hi", SRT_ADDR_RELOAD_HI, 8'h00);
    $display("test ext_mix done");
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ==========================================
  // Main sequence.
  initial begin
    repeat (4) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    t_reset();
    t_wrap16();
    t_split();
    t_clocks();
    t_capture();
    t_ext_mix();
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
